// >>> gpiow_pkg.sv
// Purpose: Shared constants and types for the I/O port block with wake-up.
// Assumes: Classic Wishbone register access, 32-bit data, byte addresses.
// Notes:   Four ports; the first three are 8 pins, the fourth 2 pins.
package gpiow_pkg;

   // Port geometry.
   localparam int NUM_PORTS = 4;
   localparam int PORT_W    = 8;
   localparam logic [PORT_W-1:0] PORT_IMPL [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'h03};

   // Register offsets, one 32-bit word each; port n adds n*PORT_STRIDE.
   localparam logic [7:0] OFF_DATA      = 8'h00;
   localparam logic [7:0] OFF_DIR       = 8'h04;
   localparam logic [7:0] OFF_PULL      = 8'h08;
   localparam logic [7:0] OFF_PIN       = 8'h0C;
   localparam logic [7:0] PORT_STRIDE   = 8'h10;
   localparam logic [7:0] OFF_WAKE_EN   = 8'h40;
   localparam logic [7:0] OFF_WAKE_STAT = 8'h44;
   localparam logic [7:0] OFF_WAKE_MASK = 8'h48;
   localparam logic [7:0] OFF_LOWPOWER  = 8'h4C;

   // Reset values.
   localparam logic [PORT_W-1:0] RST_DATA      = 8'hFF;
   localparam logic [PORT_W-1:0] RST_DIR       = 8'hFF;
   localparam logic [PORT_W-1:0] RST_PULL      = 8'h00;
   localparam logic [PORT_W-1:0] RST_WAKE_EN   = 8'h00;
   localparam logic [PORT_W-1:0] RST_WAKE_MASK = 8'h00;

   // Instruction phases: four system clocks per instruction cycle.
   localparam int          PHASES     = 4;
   localparam logic [1:0]  PHASE_READ = 2'h1;

   // Pin-facing bundle for one port.
   typedef struct packed
   {
      logic [PORT_W-1:0] out;
      logic [PORT_W-1:0] oe;
      logic [PORT_W-1:0] pull;
   } gpiow_pins_t;

   // Phase sequencer states.
   typedef enum logic [1:0] {GPIOW_T1, GPIOW_T2, GPIOW_T3, GPIOW_T4} gpiow_phase_t;

endpackage

// >>> gpiow_sync.sv
// Purpose: Three-flop synchroniser for a vector of pin inputs.
// Assumes: Pins are asynchronous to clk_i.
// Notes:   A change counts only once the second and third stages agree.
`timescale 1ns/1ns
module gpiow_sync
#(
   parameter int W = 8
)
(
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Raw and filtered levels.
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o
);
   import gpiow_pkg::*;

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // Stage one feeds only stage two; level updates per bit on agreement.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_reg  <= '1;
         s2_reg  <= '1;
         s3_reg  <= '1;
         level_o <= '1;
      end
      else
      begin
         s1_reg  <= async_i;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         level_o <= (s2_reg & s3_reg) | (level_o & (s2_reg | s3_reg));
      end
   end
endmodule

// >>> gpiow_phase.sv
// Purpose: Instruction-phase sequencer giving a one-cycle second-phase strobe.
// Assumes: Four system clocks per instruction cycle.
// Notes:   The read strobe marks the rising edge of the second phase.
`timescale 1ns/1ns
module gpiow_phase
(
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Strobe at the start of the second instruction phase.
   output logic      t2_o
);
   import gpiow_pkg::*;

   gpiow_phase_t ph_reg;
   gpiow_phase_t ph_next;

   // Next phase in a fixed ring.
   always_comb
   begin
      case (ph_reg)
         GPIOW_T1: ph_next = GPIOW_T2;
         GPIOW_T2: ph_next = GPIOW_T3;
         GPIOW_T3: ph_next = GPIOW_T4;
         GPIOW_T4: ph_next = GPIOW_T1;
         default:  ph_next = GPIOW_T1;
      endcase
   end

   // Strobe is registered so it lines up with the entry into the phase.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ph_reg <= GPIOW_T1;
         t2_o   <= 1'b0;
      end
      else
      begin
         ph_reg <= ph_next;
         t2_o   <= (ph_next == GPIOW_T2);
      end
   end
endmodule

// >>> gpiow_top.sv
// Purpose: Four bidirectional I/O ports with pull-high and first-port wake-up.
// Assumes: Classic Wishbone slave, 32-bit data; pins asynchronous to clk_i.
// Notes:   Pin reads wait for the next second-phase strobe before acking.
//          A pin read returns the level sampled at that strobe edge, so it is
//          answered in two to five cycles; writes and other reads answer in one.
//          Wake edges set status on every enabled first-port pin, awake or not.
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module gpiow_top
(
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave.
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [7:0]           adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   // Pins: one flat input vector, one output struct per port.
   input  wire logic [gpiow_pkg::NUM_PORTS*gpiow_pkg::PORT_W-1:0] pin_i,
   output gpiow_pkg::gpiow_pins_t [gpiow_pkg::NUM_PORTS-1:0]      pins_o,
   // Power and interrupt.
   output logic                      wake_req_o,
   output logic                      irq_o
);
   import gpiow_pkg::*;

   localparam int NW = NUM_PORTS * PORT_W;

   // Port registers.
   logic [PORT_W-1:0] data_reg [NUM_PORTS];
   logic [PORT_W-1:0] dir_reg  [NUM_PORTS];
   logic [PORT_W-1:0] pull_reg [NUM_PORTS];
   logic [PORT_W-1:0] port_first_wake_enable;
   logic [PORT_W-1:0] wake_stat_reg;
   logic [PORT_W-1:0] wake_mask_reg;
   logic              lowpower_reg;
   logic [PORT_W-1:0] prev_reg;
   logic [NW-1:0]     sampled_reg;

   // Bus state.
   logic              ack_reg;
   logic              wait_t2_reg;
   logic [NW-1:0]     pin_level;
   logic              t2_strobe;

   // Decode.
   wire               req       = cyc_i & stb_i & ~ack_reg;
   wire               wr        = req & we_i & sel_i[0];
   wire [1:0]         port_sel  = adr_i[5:4];
   wire [7:0]         reg_off   = {4'h0, adr_i[3:0]};
   wire               in_ports  = (adr_i < OFF_WAKE_EN);
   wire               hit_data  = in_ports & (reg_off == OFF_DATA);
   wire               hit_dir   = in_ports & (reg_off == OFF_DIR);
   wire               hit_pull  = in_ports & (reg_off == OFF_PULL);
   wire               hit_pin   = in_ports & (reg_off == OFF_PIN);
   wire               hit_wen   = (adr_i == OFF_WAKE_EN);
   wire               hit_wst   = (adr_i == OFF_WAKE_STAT);
   wire               hit_wmk   = (adr_i == OFF_WAKE_MASK);
   wire               hit_lp    = (adr_i == OFF_LOWPOWER);
   // Pin reads stall until the sampling strobe so the value is fresh.
   wire               pin_rd    = req & ~we_i & (hit_data | hit_pin);
   wire               ack_now   = req & (~pin_rd | (wait_t2_reg & t2_strobe));

   // Synchronise and sample pins.
   gpiow_sync #(.W(NW)) u_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (pin_i),
      .level_o (pin_level)
   );

   gpiow_phase u_phase
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .t2_o  (t2_strobe)
   );

   // Inputs are not latched beyond the per-instruction sample.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sampled_reg <= '1;
      else if (t2_strobe)
         sampled_reg <= pin_level;
   end

   // At the strobe edge the live level is shown, so a pin read carries the sample
   // taken at the second phase of its own access and not the one before it.
   wire [NW-1:0]     view_src = t2_strobe ? pin_level : sampled_reg;

   // Per-port read view and pin drive.
   logic [PORT_W-1:0] port_view [NUM_PORTS];
   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++)
      begin : g_port
         wire [PORT_W-1:0] smp = view_src[g*PORT_W +: PORT_W];
         // Input pins show the sampled level, output pins the latch.
         assign port_view[g] = ((dir_reg[g] & smp) | (~dir_reg[g] & data_reg[g]))
                               & PORT_IMPL[g];

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               data_reg[g]      <= RST_DATA & PORT_IMPL[g];
               dir_reg[g]       <= RST_DIR & PORT_IMPL[g];
               pull_reg[g]      <= RST_PULL;
               pins_o[g].out    <= '0;
               pins_o[g].oe     <= '0;
               pins_o[g].pull   <= '0;
            end
            else
            begin
               if (wr & hit_data & (port_sel == g))
                  data_reg[g] <= dat_i[PORT_W-1:0] & PORT_IMPL[g];
               if (wr & hit_dir & (port_sel == g))
                  dir_reg[g] <= dat_i[PORT_W-1:0] & PORT_IMPL[g];
               if (wr & hit_pull & (port_sel == g))
                  pull_reg[g] <= dat_i[PORT_W-1:0] & PORT_IMPL[g];
               pins_o[g].out  <= data_reg[g] & ~dir_reg[g];
               pins_o[g].oe   <= ~dir_reg[g] & PORT_IMPL[g];
               pins_o[g].pull <= pull_reg[g] & dir_reg[g];
            end
         end

         // Each port's enable follows its direction register one cycle later.
         oe_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
            $stable(dir_reg[g]) |-> pins_o[g].oe == (~dir_reg[g] & PORT_IMPL[g]))
            else $error("output enable does not follow direction");
      end
   endgenerate

   // Wake edge detection on the first port, on every enabled pin whatever its direction.
   wire [PORT_W-1:0] first_lvl = pin_level[PORT_W-1:0];
   wire [PORT_W-1:0] fall      = prev_reg & ~first_lvl & port_first_wake_enable;
   wire              fall_any  = |fall;

   // Read data mux.
   // Unmapped offsets fall through to zero, so probing software reads no junk.
   wire [PORT_W-1:0] rd_byte =
        (hit_data | hit_pin) ? port_view[port_sel] :
        hit_dir  ? dir_reg[port_sel]  :
        hit_pull ? pull_reg[port_sel] :
        hit_wen  ? port_first_wake_enable :
        hit_wst  ? wake_stat_reg :
        hit_wmk  ? wake_mask_reg :
        hit_lp   ? {7'h00, lowpower_reg} : 8'h00;

   // Wake and interrupt registers.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port_first_wake_enable <= RST_WAKE_EN;
         wake_mask_reg          <= RST_WAKE_MASK;
         wake_stat_reg          <= '0;
         lowpower_reg           <= 1'b0;
         prev_reg               <= '1;
         wake_req_o             <= 1'b0;
         irq_o                  <= 1'b0;
      end
      else
      begin
         prev_reg <= first_lvl;
         if (wr & hit_wen)
            port_first_wake_enable <= dat_i[PORT_W-1:0];
         if (wr & hit_wmk)
            wake_mask_reg <= dat_i[PORT_W-1:0];
         // Set beats clear so an edge in the clearing cycle is kept.
         wake_stat_reg <= (wake_stat_reg & ~((wr & hit_wst) ? dat_i[PORT_W-1:0] : 8'h00))
                          | fall;
         // Low-power flag: software sets it, a wake edge ends it.
         if (lowpower_reg & fall_any)
            lowpower_reg <= 1'b0;
         else if (wr & hit_lp)
            lowpower_reg <= dat_i[0];
         wake_req_o <= lowpower_reg & fall_any;
         irq_o      <= |(wake_stat_reg & wake_mask_reg);
      end
   end

   // Bus answer.
   // The answer is registered, so ack_o and dat_o change together and a master
   // that samples ack high at an edge finds the read data already settled.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg     <= 1'b0;
         wait_t2_reg <= 1'b0;
         dat_o       <= '0;
      end
      else
      begin
         ack_reg     <= ack_now;
         wait_t2_reg <= pin_rd & ~ack_now;
         if (ack_now)
            dat_o <= {24'h000000, rd_byte};
      end
   end
   assign ack_o = ack_reg;

   // Checks. Every property runs on clk_i and all but reset_dir_a are held off while rst_i is high,
   // because the registers only hold defined values once a reset edge has passed.

   // Wake request and the low-power flag.
   // The request is one pulse, so the power controller never acts on a stale level.
   wake_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (lowpower_reg && fall_any) |=> wake_req_o && !lowpower_reg)
      else $error("wake request missing after enabled falling edge");

   awake_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !lowpower_reg |=> !wake_req_o)
      else $error("wake request while not in low power");

   sleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (lowpower_reg && !fall_any && !(wr && hit_lp)) |=> lowpower_reg)
      else $error("low-power flag dropped without a wake edge");

   wake_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_req_o |-> $past(fall_any))
      else $error("wake request without a falling edge");

   single_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_req_o |=> !wake_req_o)
      else $error("wake request longer than one cycle");

   // Edge detection and the sticky status.
   // A pin held low must stay quiet, otherwise a stuck switch would keep waking the core.
   no_static_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ($past(first_lvl) == first_lvl) |-> !fall_any)
      else $error("static level retriggered wake");

   edge_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fall_any |=> (fall & $past(fall)) == 8'h00)
      else $error("one falling edge seen twice");

   stat_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fall_any |=> (wake_stat_reg & $past(fall)) == $past(fall))
      else $error("wake status lost an edge");

   stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_wst && !fall_any) |=> (wake_stat_reg & $past(dat_i[7:0])) == 8'h00)
      else $error("wake status not cleared by a one");

   wen_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_wen) |=> port_first_wake_enable == $past(dat_i[7:0]))
      else $error("wake enable write lost");

   // Pin drive and pull-high.
   // The pull is cut on output pins, so it never fights the push-pull driver.
   drive_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $stable(dir_reg[0]) && $stable(data_reg[0]) |-> pins_o[0].oe == ~dir_reg[0]
      && pins_o[0].out == (data_reg[0] & ~dir_reg[0]))
      else $error("output drive does not follow latch");

   pull_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 pins_o[1].pull == $past(pull_reg[1] & dir_reg[1]))
      else $error("pull-high not gated by direction");

   pull_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pins_o[2].pull & pins_o[2].oe) == 8'h00)
      else $error("pull-high on while driving");

   pull_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_pull && port_sel == 2'h2) |=> pull_reg[2] == $past(dat_i[7:0]))
      else $error("pull-high write lost");

   // Register writes and the read view.
   // Input bits show the pin, output bits the latch; both are checked on port 0.
   dir_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_dir && port_sel == 2'h0) |=> dir_reg[0] == $past(dat_i[7:0]))
      else $error("direction write lost");

   in_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (port_view[0] & dir_reg[0]) == (view_src[7:0] & dir_reg[0]))
      else $error("input bit does not show the pin");

   out_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (port_view[0] & ~dir_reg[0]) == (data_reg[0] & ~dir_reg[0]))
      else $error("output bit does not show the latch");

   rd_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_now && hit_data && !we_i) |=> dat_o[7:0] == ($past(port_view[port_sel])))
      else $error("port read returned wrong view");

   dat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ack_now |=> $stable(dat_o))
      else $error("read data moved without an answer");

   data_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_data && port_sel == 2'h1) |=> data_reg[1] == $past(dat_i[7:0]))
      else $error("data latch write lost");

   latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wr && hit_data && port_sel == 2'h0) |=> $stable(data_reg[0]))
      else $error("output latch changed without a write");

   // Sampling at the second instruction phase.
   // Between strobes the sample must not move, or a read could see a half-settled pin.
   sample_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !t2_strobe |=> $stable(sampled_reg))
      else $error("pin sample moved between strobes");

   strobe_ring_a: assert property (@(posedge clk_i) disable iff (rst_i)
      t2_strobe |=> !t2_strobe ##1 !t2_strobe ##1 !t2_strobe ##1 t2_strobe)
      else $error("phase strobe not once per instruction");

   rd_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pin_rd && !wait_t2_reg) |-> ##[1:5] ack_o)
      else $error("pin read not answered within one instruction");

   // Reset values and unimplemented bits.
   // Port 3 has two pins; its upper bits must stay dead in every register and drive.
   reset_dir_a: assert property (@(posedge clk_i)
      $past(rst_i) |-> dir_reg[0] == RST_DIR && data_reg[0] == RST_DATA)
      else $error("port reset values wrong");

   unimpl_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (data_reg[3][7:2] == 6'h00) && (dir_reg[3][7:2] == 6'h00))
      else $error("unimplemented port bits not zero");

   port3_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pins_o[3].oe[7:2] == 6'h00) && (pins_o[3].out[7:2] == 6'h00)
      && (pins_o[3].pull[7:2] == 6'h00))
      else $error("unimplemented pin drive not zero");
endmodule

// >>> gpiow_pin_model.sv
// Purpose: Model of the switches and wiring that sit on the port pins.
// Assumes: The device beats a switch, a switch beats the weak pull-high.
// Notes:   A floating pin without pull-high reads low, so a missing pull shows up.
`timescale 1ns/1ns
module gpiow_pin_model
(
   // Device side of the wires.
   input  wire gpiow_pkg::gpiow_pins_t [3:0] pins_i,
   // Switch side of the wires.
   input  wire logic [31:0]                 ext_en_i,
   input  wire logic [31:0]                 ext_val_i,
   output logic      [31:0]                 level_o
);
   import gpiow_pkg::*;
   // Resolve each wire from every party that may drive it.
   // An undriven wire with no pull-high sits low, the opposite of the pull level.
   always_comb
   begin
      for (int i = 0; i < 32; i++)
      begin
         if (pins_i[i/8].oe[i%8])
            level_o[i] = pins_i[i/8].out[i%8];
         else if (ext_en_i[i])
            level_o[i] = ext_val_i[i];
         else
            level_o[i] = pins_i[i/8].pull[i%8] ? 1'b1 : 1'b0;
      end
   end
endmodule

// >>> gpiow_top_test.sv
// Purpose: Self-checking bench for the I/O port block with wake-up.
// Assumes: Registers are reached by single classic Wishbone cycles.
// Notes:   Pin reads allow for the synchroniser and the phase wait.
`timescale 1ns/1ns
module gpiow_top_test;
   import gpiow_pkg::*;
   logic                         clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, wake_req_o, irq_o;
   logic      [7:0]              adr_i;
   logic      [3:0]              sel_i;
   logic      [31:0]             dat_i, dat_o, pin_i, ext_en, ext_val;
   gpiow_pins_t [NUM_PORTS-1:0]  pins_o;
   int                           failures, compares;
   logic      [31:0]             q;
   // Design and the wiring model on its pins.
   gpiow_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .pin_i(pin_i), .pins_o(pins_o), .wake_req_o(wake_req_o), .irq_o(irq_o));
   gpiow_pin_model pins (.pins_i(pins_o), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .level_o(pin_i));
   // Clock at 125 MHz.
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Report the counts and the verdict, then stop.
   task automatic complete_run;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; the wait is bounded so a silent slave ends the run.
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 40);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n == 40)
      begin
         failures++;
         complete_run();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      wb(a, 1'b0, 8'h00);
      chk(q, {24'h000000, e});
   endtask
   task automatic reset_values;
      rd_chk(OFF_DIR, 8'hFF);
      rd_chk(OFF_DATA, 8'hFF);
      rd_chk(8'h34, 8'h03);
      rd_chk(8'h30, 8'h03);
      rd_chk(OFF_PULL, 8'h00);
      rd_chk(OFF_WAKE_EN, 8'h00);
      rd_chk(8'hFC, 8'h00);
   endtask
   // Low nibble output from the latch, high nibble input from switches.
   task automatic output_latch;
      wb(8'h10, 1'b1, 8'hA5);
      wb(8'h14, 1'b1, 8'hF0);
      ext_val[15:8] <= 8'h3C;
      repeat (8) @(posedge clk_i);
      chk(pins_o[1].oe, 8'h0F);
      chk(pins_o[1].out & 8'h0F, 8'h05);
      rd_chk(8'h10, 8'h35);
      ext_val[15:8] <= 8'hC3;
      repeat (8) @(posedge clk_i);
      rd_chk(8'h10, 8'hC5);
      rd_chk(8'h1C, 8'hC5);
      chk(pins_o[1].out & 8'h0F, 8'h05);
   endtask
   // Switches open; only the pull-high holds the wires up.
   task automatic pull_high;
      wb(8'h28, 1'b1, 8'hFF);
      ext_en[23:16] <= 8'h00;
      repeat (8) @(posedge clk_i);
      chk(pins_o[2].pull, 8'hFF);
      rd_chk(8'h20, 8'hFF);
      sel_i <= 4'h0;
      wb(8'h28, 1'b1, 8'h00);
      sel_i <= 4'hF;
      rd_chk(8'h28, 8'hFF);
      wb(8'h28, 1'b1, 8'h00);
      repeat (8) @(posedge clk_i);
      chk(pins_o[2].pull, 8'h00);
      rd_chk(8'h20, 8'h00);
   endtask
   // Two pins fall, only pin 0 is enabled; a held low must not re-fire.
   task automatic wake;
      int n;
      wb(OFF_WAKE_EN, 1'b1, 8'h01);
      wb(OFF_WAKE_MASK, 1'b1, 8'h01);
      wb(OFF_LOWPOWER, 1'b1, 8'h01);
      ext_val[1:0] <= 2'b00;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wake_req_o !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h1);
      if (n == 20)
         complete_run();
      rd_chk(OFF_WAKE_STAT, 8'h01);
      rd_chk(OFF_LOWPOWER, 8'h00);
      chk(32'(irq_o), 32'h1);
      wb(OFF_WAKE_STAT, 1'b1, 8'h01);
      repeat (20) @(posedge clk_i);
      rd_chk(OFF_WAKE_STAT, 8'h00);
      chk(32'(irq_o), 32'h0);
   endtask
   // Reset for three cycles, then the scenarios in turn.
   initial
   begin
      failures = 0;
      compares = 0;
      rst_i   = 1'b1;
      cyc_i   = 1'b0;
      stb_i   = 1'b0;
      we_i    = 1'b0;
      adr_i   = 8'h00;
      sel_i   = 4'hF;
      dat_i   = 32'h00000000;
      ext_en  = 32'hFFFFFFFF;
      ext_val = 32'hFFFFFFFF;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      reset_values();
      output_latch();
      pull_high();
      wake();
      complete_run();
   end
endmodule
